// File: rtl/abu_addr_compare.sv
`timescale 1ns/1ps
// Registered program-counter match, qualified by enable, pcValid and low power
module abu_addr_compare #(
  parameter int ADDR_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              lowPower,
  input  wire logic              pcValid,
  input  wire logic [ADDR_W-1:0] pcAddr,
  input  wire logic [ADDR_W-1:0] breakAddr,
  output logic                   hit
);
  typedef struct packed {
    logic hit;
  } abu_cmp_state_t;
  abu_cmp_state_t state;
  abu_cmp_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.hit = enable && pcValid && !lowPower && (pcAddr == breakAddr);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign hit = state.hit;
endmodule

// File: rtl/abu_bus_slave.sv
`timescale 1ns/1ps
// AHB-Lite address-phase capture; zero wait state
module abu_bus_slave (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic                 hready,
  output abu_pkg::abu_bus_req_t     dataPhase
);
  abu_pkg::abu_bus_req_t state;
  abu_pkg::abu_bus_req_t next_state;

  always_comb begin
    next_state = state;
    if (hready) begin
      next_state.valid = hsel && htrans[1];
      next_state.write = hwrite;
      next_state.addr  = haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dataPhase = state;
endmodule

// File: rtl/abu_pkg.sv
package abu_pkg;
  // Register byte addresses, one aligned word each
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_BRK_HIGH    = 8'h04;
  localparam logic [7:0] ADDR_BRK_LOW     = 8'h08;
  localparam logic [7:0] ADDR_AUXILIARY   = 8'h0C;
  localparam logic [7:0] ADDR_WAIT_EXIT   = 8'h10;
  localparam logic [7:0] ADDR_FLAG_CLEAR  = 8'h14;
  // Field positions
  localparam int BIT_BREAK_ENABLE = 7;
  localparam int BIT_BREAK_ACTIVE = 6;
  localparam int BIT_WDOG_OFF     = 0;
  localparam int BIT_WAIT_EXIT    = 1;
  localparam int BIT_FLAG_CLEAR   = 7;
  // Reset values and AHB-Lite codes
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HRESP_OKAY    = 2'b00;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
  } abu_bus_req_t;

  typedef struct packed {
    logic        breakEnable;
    logic        breakActive;
    logic [15:0] breakAddr;
    logic        watchdogOffInBreak;
    logic        waitExitByBreakFlag;
    logic        flagClearInBreakEnable;
  } abu_regs_t;
endpackage

// File: rtl/address_breakpoint_unit.sv
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
// Overview of operation
// - Enabled address match raises breakpoint request
// - Writing one to active forces break
// - Opcode match: instruction waits for handler
// - Operand match: instruction completes first
// - Forced break taken before next instruction
// - Enable bit seven gates full match
// - Active set by match, cleared by zero
// - Address high, low bytes; reset zero
// - Unchanged address never rebreaks after handler; code rearms whenever the registered hit is low
// - Flag clearing in break needs enable
// - Break freezes timer and blocks capture
// - Watchdog off in monitor break when set
// - Flag records wait exit by break
// - Wait-exit status works only in emulation
// - Low power modes raise no break
// - Compare uses program counter addresses

module address_breakpoint_unit (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AHB-Lite register port
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,

  // CPU and integration logic side
  input  wire logic        pcValid,
  input  wire logic [15:0] pcAddr,
  input  wire logic        opcodeFetch,
  input  wire logic        instrBoundary,
  input  wire logic        breakAccept,
  input  wire logic        breakReturn,
  input  wire logic        waitMode,
  input  wire logic        stopMode,
  input  wire logic        waitExit,
  input  wire logic        monitorMode,
  input  wire logic        emulationMode,

  // Break state controls
  output logic             breakpointRequest,
  output logic             holdOpcode,
  output logic             breakState,
  output logic             timerFreeze,
  output logic             captureBlock,
  output logic             watchdogSuppress,
  output logic             flagClearAllowed
);
  typedef struct packed {
    // Software visible registers
    abu_pkg::abu_regs_t regs;

    // Break request bookkeeping
    logic               request;
    logic               pendOpcode;
    logic               pendOperand;
    logic               matchArmed;
    logic               fetchWasOpcode;
    logic               inBreak;

    // Registered outputs
    logic [31:0]        rdata;
    logic               timerFreeze;
    logic               captureBlock;
    logic               watchdogSuppress;
    logic               flagClearAllowed;
    logic               holdOpcode;
  } abu_top_state_t;

  abu_top_state_t        state;
  abu_top_state_t        next_state;
  abu_pkg::abu_bus_req_t dataPhase;
  logic                  hit;
  logic                  lowPower;
  logic                  hitFetch;
  logic                  hitPending;
  // Bus side strobes
  logic                  addrRead;
  logic                  wrEnable;
  logic                  wrCtrl;
  logic                  wrWait;
  // Break side strobes
  logic                  waitSet;
  logic                  breakTaken;

  function automatic logic [31:0] readMux(input logic [7:0] addr, input abu_pkg::abu_regs_t r);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      abu_pkg::ADDR_CTRL_STATUS: begin
        v[abu_pkg::BIT_BREAK_ENABLE] = r.breakEnable;
        v[abu_pkg::BIT_BREAK_ACTIVE] = r.breakActive;
      end
      abu_pkg::ADDR_BRK_HIGH: begin
        v[7:0] = r.breakAddr[15:8];
      end
      abu_pkg::ADDR_BRK_LOW: begin
        v[7:0] = r.breakAddr[7:0];
      end
      abu_pkg::ADDR_AUXILIARY: begin
        v[abu_pkg::BIT_WDOG_OFF] = r.watchdogOffInBreak;
      end
      abu_pkg::ADDR_WAIT_EXIT: begin
        v[abu_pkg::BIT_WAIT_EXIT] = r.waitExitByBreakFlag;
      end
      abu_pkg::ADDR_FLAG_CLEAR: begin
        v[abu_pkg::BIT_FLAG_CLEAR] = r.flagClearInBreakEnable;
      end
      // Unmapped offsets read as zero
      default:                  v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Operand and forced breaks only at a boundary
  function automatic logic takeNow(input logic accept, input logic pendOp, input logic pendOpnd,
                                   input logic boundary);
    return accept && (pendOp || (pendOpnd && boundary));
  endfunction

  function automatic logic requestOf(input logic pendOp, input logic pendOpnd);
    return pendOp || pendOpnd;
  endfunction

  function automatic logic watchdogOff(input logic inBrk, input logic monitor, input logic offBit);
    return inBrk && monitor && offBit;
  endfunction

  function automatic logic clearAllowed(input logic inBrk, input logic enableBit);
    return !inBrk || enableBit;
  endfunction

  // Set by match wins over a software clear
  function automatic logic activeNext(input logic cur, input logic matchSet, input logic wr,
                                      input logic wrData);
    logic v;
    v = cur;
    if (wr && !wrData) begin
      v = 1'b0;
    end
    if (matchSet || (wr && wrData)) begin
      v = 1'b1;
    end
    return v;
  endfunction

  // Hardware set wins over a software clear
  function automatic logic waitFlagNext(input logic cur, input logic set, input logic wr,
                                        input logic wrData);
    logic v;
    v = cur;
    if (wr && !wrData) begin
      v = 1'b0;
    end
    if (set) begin
      v = 1'b1;
    end
    return v;
  endfunction

  // Wait and stop freeze the address bus
  assign lowPower = waitMode || stopMode;

  // Data-phase capture of the register bus
  abu_bus_slave u_bus (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .dataPhase (dataPhase)
  );

  // Registered program-counter compare
  abu_addr_compare #(
    .ADDR_W (16)
  ) u_cmp (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .enable    (state.regs.breakEnable),
    .lowPower  (lowPower),
    .pcValid   (pcValid),
    .pcAddr    (pcAddr),
    .breakAddr (state.regs.breakAddr),
    .hit       (hit)
  );

  // Read data fetched in the address phase so it stands in the data phase
  assign addrRead = hsel && htrans[1] && hready && !hwrite;
  assign wrEnable = dataPhase.valid && dataPhase.write;
  assign wrCtrl   = wrEnable && (dataPhase.addr == abu_pkg::ADDR_CTRL_STATUS);
  assign wrWait   = wrEnable && (dataPhase.addr == abu_pkg::ADDR_WAIT_EXIT);
  assign waitSet  = emulationMode && waitExit && state.inBreak;

  // Accepted only at a boundary unless opcode hold
  assign breakTaken = takeNow(breakAccept, state.pendOpcode, state.pendOperand, instrBoundary);

  // Rearm whenever the registered hit is low
  assign hitPending = hit && state.matchArmed && !state.inBreak;
  assign hitFetch   = hitPending && state.fetchWasOpcode;

  always_comb begin
    next_state       = state;
    next_state.rdata = 32'h0000_0000;

    // Fetch kind kept in step with the registered hit
    next_state.fetchWasOpcode = opcodeFetch;

    // Same address disarms after one break
    if (hit && !state.inBreak) begin
      next_state.matchArmed = 1'b0;
    end else if (!hit) begin
      next_state.matchArmed = 1'b1;
    end

    if (hitPending) begin
      if (hitFetch) begin
        next_state.pendOpcode = 1'b1;
      end else begin
        // Operand match waits for instruction end
        next_state.pendOperand = 1'b1;
      end
    end

    // Match sets, zero clears, match wins
    next_state.regs.breakActive = activeNext(state.regs.breakActive, hitPending, wrCtrl,
                                             hwdata[abu_pkg::BIT_BREAK_ACTIVE]);

    // Forced break taken at next boundary
    if (wrCtrl && hwdata[abu_pkg::BIT_BREAK_ACTIVE]) begin
      next_state.pendOperand = 1'b1;
    end

    next_state.regs.waitExitByBreakFlag = waitFlagNext(state.regs.waitExitByBreakFlag, waitSet, wrWait,
                                                       hwdata[abu_pkg::BIT_WAIT_EXIT]);

    if (wrEnable) begin
      unique case (dataPhase.addr)
        abu_pkg::ADDR_CTRL_STATUS: begin
          next_state.regs.breakEnable = hwdata[abu_pkg::BIT_BREAK_ENABLE];
        end
        abu_pkg::ADDR_BRK_HIGH: begin
          next_state.regs.breakAddr[15:8] = hwdata[7:0];
        end
        abu_pkg::ADDR_BRK_LOW: begin
          next_state.regs.breakAddr[7:0] = hwdata[7:0];
        end
        abu_pkg::ADDR_AUXILIARY: begin
          next_state.regs.watchdogOffInBreak = hwdata[abu_pkg::BIT_WDOG_OFF];
        end
        abu_pkg::ADDR_FLAG_CLEAR: begin
          next_state.regs.flagClearInBreakEnable = hwdata[abu_pkg::BIT_FLAG_CLEAR];
        end
        default: begin
        end
      endcase
    end

    next_state.request    = requestOf(next_state.pendOpcode, next_state.pendOperand);
    next_state.holdOpcode = next_state.pendOpcode;

    if (breakTaken) begin
      next_state.pendOpcode  = 1'b0;
      next_state.pendOperand = 1'b0;
      next_state.request     = 1'b0;
      next_state.holdOpcode  = 1'b0;
      next_state.inBreak     = 1'b1;
    end

    if (breakReturn && state.inBreak) begin
      next_state.inBreak = 1'b0;
    end

    next_state.timerFreeze  = next_state.inBreak;
    next_state.captureBlock = next_state.inBreak;

    next_state.watchdogSuppress = watchdogOff(next_state.inBreak, monitorMode, next_state.regs.watchdogOffInBreak);

    next_state.flagClearAllowed = clearAllowed(next_state.inBreak, next_state.regs.flagClearInBreakEnable);

    // Read image taken after writes, so a landing write is seen
    if (addrRead) begin
      next_state.rdata = readMux(haddr[7:0], next_state.regs);
    end
  end

  // Reset leaves the compare armed and flag clearing open
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.matchArmed <= 1'b1;
      state.flagClearAllowed <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign hreadyout         = 1'b1;
  assign hresp             = abu_pkg::HRESP_OKAY[0];
  assign hrdata            = state.rdata;

  // Break state to the integration logic
  assign breakpointRequest = state.request;
  assign holdOpcode        = state.holdOpcode;
  assign breakState        = state.inBreak;

  // Side controls during a break
  assign timerFreeze       = state.timerFreeze;
  assign captureBlock      = state.captureBlock;
  assign watchdogSuppress  = state.watchdogSuppress;
  assign flagClearAllowed  = state.flagClearAllowed;
endmodule

// File: sim/abu_assertions.sv
`timescale 1ns/1ps
module abu_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instrBoundary,
  input wire logic breakAccept,
  input wire logic breakReturn,
  input wire logic breakpointRequest,
  input wire logic holdOpcode,
  input wire logic breakState,
  input wire logic timerFreeze,
  input wire logic captureBlock,
  input wire logic watchdogSuppress,
  input wire logic flagClearAllowed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; breakpointRequest && breakAccept && (holdOpcode || instrBoundary); endsequence
  sequence s_enter; !breakpointRequest && breakState; endsequence
  property p_take; s_take |=> s_enter; endproperty
  property p_pend; breakpointRequest && !breakAccept |=> breakpointRequest; endproperty
  property p_opnd; breakpointRequest && !breakState && !holdOpcode && !instrBoundary |=> !breakState; endproperty
  property p_hold; holdOpcode |-> breakpointRequest; endproperty
  property p_ret; breakState && breakReturn |=> !breakState; endproperty
  property p_frz; timerFreeze == breakState && captureBlock == breakState; endproperty
  property p_wdog; watchdogSuppress |-> breakState; endproperty
  property p_flag; !flagClearAllowed |-> breakState; endproperty
  a_take: assert property (p_take) else $error("break not entered after accept");
  a_pend: assert property (p_pend) else $error("request dropped before accept");
  a_opnd: assert property (p_opnd) else $error("operand break taken mid instruction");
  a_hold: assert property (p_hold) else $error("opcode hold without request");
  a_ret: assert property (p_ret) else $error("break state kept after return");
  a_frz: assert property (p_frz) else $error("timer freeze differs from break state");
  a_wdog: assert property (p_wdog) else $error("watchdog held off outside break");
  a_flag: assert property (p_flag) else $error("flag clearing blocked outside break");
endmodule
bind address_breakpoint_unit abu_assertions u_chk (.*);

// File: sim/abu_cpu_model.sv
`timescale 1ns/1ps
// CPU and integration side: runs code, takes and ends breaks
module abu_cpu_model (
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  input  wire logic   run,
  input  wire logic   leave,
  input  wire logic   breakpointRequest,
  input  wire logic   holdOpcode,
  output logic        pcValid,
  output logic [15:0] pcAddr,
  output logic        opcodeFetch,
  output logic        instrBoundary,
  output logic        breakAccept,
  output logic        breakReturn
);
  logic [1:0] phase;
  logic       inBrk;
  // Three-byte instructions, opcode first
  assign opcodeFetch = phase == 2'h0;
  assign instrBoundary = opcodeFetch && pcValid;
  assign breakAccept = breakpointRequest && !inBrk && (holdOpcode || instrBoundary);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcValid <= 1'b0;
      pcAddr <= 16'h0100;
      phase <= 2'h0;
      inBrk <= 1'b0;
      breakReturn <= 1'b0;
    end else if (breakAccept) begin
      inBrk <= 1'b1;
      pcValid <= 1'b0;
    end else if (inBrk) begin
      breakReturn <= leave;
      inBrk <= !leave;
    end else begin
      breakReturn <= 1'b0;
      pcValid <= run;
      if (run) begin
        pcAddr <= pcAddr + 16'h0001;
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      end
    end
  end
endmodule

// File: sim/tb_address_breakpoint_unit.sv
`timescale 1ns/1ps
module tb_address_breakpoint_unit;
  logic        sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, run, leave, waitMode, stopMode, waitExit;
  logic        monitorMode, emulationMode, pcValid, opcodeFetch, instrBoundary, breakAccept, breakReturn;
  logic        breakpointRequest, holdOpcode, breakState, timerFreeze, captureBlock, watchdogSuppress;
  logic        flagClearAllowed;
  logic [1:0]  htrans;
  logic [15:0] pcAddr;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  int          errCount = 0;
  int          numChecks = 0;
  address_breakpoint_unit DUT (.*, .hsize(3'h2), .hready(hreadyout));
  abu_cpu_model u_cpu (.*);
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= abu_pkg::HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdv, exp);
  endtask
  task automatic waitBrk(input logic e);
    for (int i = 0; i < 60 && breakState !== e; i++) @(posedge sys_clk);
    chk(32'(breakState), 32'(e));
  endtask
  task automatic endBrk;
    leave <= 1'b1;
    @(posedge sys_clk);
    leave <= 1'b0;
    waitBrk(1'b0);
  endtask
  task automatic tRegs;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0000_0000);
    bus(1'b1, 8'h04, 32'hFFFF_FFA5);
    bus(1'b1, 8'h08, 32'h0000_005A);
    bus(1'b1, 8'h18, 32'h0000_00FF);
    rd(8'h04, 32'h0000_00A5);
    rd(8'h08, 32'h0000_005A);
    rd(8'h18, 32'h0000_0000);
  endtask
  task automatic tMatch;
    monitorMode <= 1'b1;
    emulationMode <= 1'b1;
    bus(1'b1, 8'h04, 32'h0000_0001);
    bus(1'b1, 8'h08, 32'h0000_0009);
    bus(1'b1, 8'h0C, 32'h0000_0001);
    bus(1'b1, 8'h00, 32'h0000_0080);
    run <= 1'b1;
    waitBrk(1'b1);
    repeat (2) @(posedge sys_clk);
    chk(32'({timerFreeze, captureBlock, watchdogSuppress, flagClearAllowed}), 32'h0000_000E);
    rd(8'h00, 32'h0000_00C0);
    waitExit <= 1'b1;
    @(posedge sys_clk);
    waitExit <= 1'b0;
    rd(8'h10, 32'h0000_0002);
    bus(1'b1, 8'h14, 32'h0000_0080);
    repeat (2) @(posedge sys_clk);
    chk(32'(flagClearAllowed), 32'h0000_0001);
    bus(1'b1, 8'h10, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0080);
    rd(8'h10, 32'h0000_0000);
    endBrk;
    repeat (30) @(posedge sys_clk);
    chk(32'(breakState), 32'h0000_0000);
  endtask
  task automatic tForce;
    bus(1'b1, 8'h00, 32'h0000_0040);
    waitBrk(1'b1);
    rd(8'h00, 32'h0000_0040);
    bus(1'b1, 8'h00, 32'h0000_0000);
    endBrk;
  endtask
  task automatic tLow;
    logic [15:0] t;
    logic [31:0] c;
    for (int m = 0; m < 3; m++) begin
      {stopMode, waitMode} <= 2'(m);
      t = pcAddr + 16'h0020;
      c = (m == 0) ? 32'h0000_0000 : 32'h0000_0080;
      bus(1'b1, 8'h04, 32'(t[15:8]));
      bus(1'b1, 8'h08, 32'(t[7:0]));
      bus(1'b1, 8'h00, c);
      repeat (40) @(posedge sys_clk);
      rd(8'h00, c);
    end
  endtask
  task automatic reportAndStop;
    if (errCount == 0 && numChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {sys_clk, rst_n, hsel, hwrite, run, leave, waitMode, stopMode, waitExit, monitorMode, emulationMode} = '0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    tRegs;
    tMatch;
    tForce;
    tLow;
    reportAndStop;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errCount++;
    reportAndStop;
  end
endmodule
